// [hw/sacc_ctrl.sv]
`timescale 1ns/100ps
module sacc_ctrl #(
   parameter int DIV_MAX_LOG = 4
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic bus_clk_en,
   input wire logic osc_clk_en,
   input wire logic stop_mode,
   output logic [4:0] analog_mux_sel,
   output logic analog_power_on,
   output logic comparator_sample,
   output logic [SACC_BITS-1:0] dac_trial_code,
   input wire logic comparator_above,
   input wire logic [7:0] port_out_req,
   input wire logic [7:0] port_dir_req,
   input wire logic [7:0] shared_analog_port_pins_in,
   output logic [7:0] shared_analog_port_pins_out,
   output logic [7:0] shared_analog_port_pins_oe,
   output logic [7:0] port_read_data,
   output logic conv_irq,
   output logic wake_request
);
   import sacc_pkg::*;

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   // Divider counter is four bits, ratio at most 16
   if (DIV_MAX_LOG != 4) begin : g_bad_div
      $error("DIV_MAX_LOG must be 4");
   end
   // Bit index counter is four bits
   if (SACC_BITS > 15 || SACC_CONV_CYCLES > 16) begin : g_bad_count
      $error("bit or cycle count too large for counters");
   end
   // Sample phase needs room before the trials
   if (SACC_CONV_CYCLES <= SACC_BITS) begin : g_bad_phase
      $error("conversion shorter than trial count");
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [4:0] channel_select_field;
   logic continuous_conv_bit;
   logic conv_irq_enable;
   logic conv_complete_flag;
   logic [2:0] conv_clock_prescaler;
   logic conv_clock_source_sel;
   logic [1:0] format_sel;
   logic [7:0] result_high_reg;
   logic [7:0] result_low_reg;
   logic hold_low;
   logic irq_pend;
   logic [SACC_BITS-1:0] sar;
   logic [3:0] bit_idx;
   logic [3:0] div_cnt;
   sacc_state_t state;
   logic single_pending;
   logic rd_ack;

   logic wr_csr;
   logic wr_clk;
   logic rd_rhi;
   logic rd_rlo;
   logic rd_data;
   logic conv_tick;
   logic conv_done;
   logic powered;
   logic pin_claimed;
   logic [7:0] claim_mask;
   logic [15:0] div_ratio;
   logic src_tick;
   logic interlocked;
   logic trial_done;
   logic [31:0] next_readdata;

   // Reads wait one cycle so registered data stands at the taking edge
   assign avs_waitrequest = avs_read && !rd_ack;
   assign wr_csr = avs_write && avs_address == SACC_OFS_CSR && avs_byteenable[0];
   assign wr_clk = avs_write && avs_address == SACC_OFS_CLK && avs_byteenable[0];
   // Read side effects fire once, in the cycle the data is captured
   assign rd_rhi = avs_read && !rd_ack && avs_address == SACC_OFS_RHI;
   assign rd_rlo = avs_read && !rd_ack && avs_address == SACC_OFS_RLO;
   assign rd_data = rd_rhi || rd_rlo;
   assign powered = channel_select_field != SACC_CH_OFF && !stop_mode;
   assign interlocked = format_sel != SACC_FMT_TRUNC;

   // ----------------------------------------
   // Pin sharing
   // ----------------------------------------
   assign pin_claimed = channel_select_field <= SACC_CH_LAST_PIN;
   assign claim_mask = pin_claimed ? 8'(8'h01 << channel_select_field[2:0]) : 8'h00;
   assign shared_analog_port_pins_out = port_out_req & ~claim_mask;
   assign shared_analog_port_pins_oe = port_dir_req & ~claim_mask;
   assign port_read_data = shared_analog_port_pins_in & ~claim_mask;
   assign analog_mux_sel = channel_select_field;
   assign analog_power_on = powered;

   // ----------------------------------------
   // Converter clock enable
   // ----------------------------------------
   always_comb begin
      div_ratio = conv_clock_prescaler[2] ? 16'h0010 : 16'(16'h0001 << conv_clock_prescaler[1:0]);
   end
   assign src_tick = conv_clock_source_sel ? bus_clk_en : osc_clk_en;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= 4'h0;
      end else if (src_tick) begin
         if (16'(div_cnt) + 16'h0001 >= div_ratio) begin
            div_cnt <= 4'h0;
         end else begin
            div_cnt <= div_cnt + 4'h1;
         end
      end
   end
   // One converter tick per ratio input clock pulses
   assign conv_tick = src_tick && (16'(div_cnt) + 16'h0001 >= div_ratio);

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         channel_select_field <= SACC_CH_RST;
         continuous_conv_bit <= 1'b0;
         conv_irq_enable <= 1'b0;
      end else if (wr_csr) begin
         channel_select_field <= avs_writedata[4:0];
         continuous_conv_bit <= avs_writedata[SACC_CSR_CONT_POS];
         conv_irq_enable <= avs_writedata[SACC_CSR_IEN_POS];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_clock_prescaler <= SACC_DIV_RST;
         conv_clock_source_sel <= 1'b0;
         format_sel <= SACC_FMT_RST;
      end else if (wr_clk) begin
         conv_clock_prescaler <= avs_writedata[SACC_CLK_DIV_POS +: 3];
         conv_clock_source_sel <= avs_writedata[SACC_CLK_SRC_POS];
         format_sel <= avs_writedata[SACC_CLK_FMT_POS +: 2];
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic settle_need;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         settle_need <= 1'b1;
      end else if (!powered) begin
         settle_need <= 1'b1;
      end else if (state == SACC_SETTLE && conv_done) begin
         settle_need <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         single_pending <= 1'b0;
      end else if (wr_csr) begin
         single_pending <= 1'b1;
      end else if (trial_done) begin
         // Held through an abort so the conversion restarts from the beginning
         single_pending <= 1'b0;
      end
   end

   assign conv_done = conv_tick && bit_idx == 4'h0 && state != SACC_SAMPLE && state != SACC_IDLE;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= SACC_IDLE;
         bit_idx <= 4'h0;
         sar <= '0;
      end else if (!powered || wr_csr) begin
         // Power loss or control write aborts at once
         state <= SACC_IDLE;
         bit_idx <= 4'h0;
      end else begin
         case (state)
            SACC_IDLE: begin
               if (single_pending || continuous_conv_bit) begin
                  state <= settle_need ? SACC_SETTLE : SACC_SAMPLE;
                  bit_idx <= 4'(SACC_CONV_CYCLES - 1);
               end
            end
            SACC_SETTLE: begin
               if (conv_tick) begin
                  bit_idx <= bit_idx - 4'h1;
                  if (bit_idx == 4'h0) begin
                     state <= SACC_SAMPLE;
                     bit_idx <= 4'(SACC_CONV_CYCLES - 1);
                  end
               end
            end
            SACC_SAMPLE: begin
               if (conv_tick && bit_idx <= 4'(SACC_BITS)) begin
                  state <= SACC_TRIAL;
                  sar <= 10'h200;
                  bit_idx <= 4'(SACC_BITS - 1);
               end else if (conv_tick) begin
                  bit_idx <= bit_idx - 4'h1;
               end
            end
            SACC_TRIAL: begin
               if (conv_tick) begin
                  // Keep or drop tried bit, try next lower
                  if (!comparator_above) begin
                     sar[bit_idx] <= 1'b0;
                  end
                  if (bit_idx != 4'h0) begin
                     sar[bit_idx - 4'h1] <= 1'b1;
                     bit_idx <= bit_idx - 4'h1;
                  end else begin
                     state <= SACC_IDLE;
                  end
               end
            end
            default: state <= SACC_IDLE;
         endcase
      end
   end

   assign comparator_sample = state == SACC_TRIAL && conv_tick;
   assign dac_trial_code = sar;

   logic [SACC_BITS-1:0] final_code;
   assign trial_done = state == SACC_TRIAL && conv_tick && bit_idx == 4'h0 && powered && !wr_csr;
   assign final_code = {sar[SACC_BITS-1:1], comparator_above};

   // ----------------------------------------
   // Result registers and interlock
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hold_low <= 1'b0;
      end else if (rd_rlo || !interlocked) begin
         hold_low <= 1'b0;
      end else if (rd_rhi) begin
         // High read locks the pair until the low read
         hold_low <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         result_high_reg <= 8'h00;
         result_low_reg <= 8'h00;
      // A high read in the same cycle keeps the captured pair consistent
      end else if (trial_done && !(interlocked && (hold_low || rd_rhi))) begin
         case (format_sel)
            SACC_FMT_TRUNC: begin
               result_high_reg <= 8'h00;
               result_low_reg <= final_code[9:2];
            end
            SACC_FMT_RIGHT: begin
               result_high_reg <= {6'h00, final_code[9:8]};
               result_low_reg <= final_code[7:0];
            end
            SACC_FMT_LEFT: begin
               result_high_reg <= final_code[9:2];
               result_low_reg <= {final_code[1:0], 6'h00};
            end
            default: begin
               result_high_reg <= {~final_code[9], final_code[8:2]};
               result_low_reg <= {final_code[1:0], 6'h00};
            end
         endcase
      end
   end

   // ----------------------------------------
   // Flag and interrupt request
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         conv_complete_flag <= 1'b0;
      end else if (trial_done && !conv_irq_enable) begin
         conv_complete_flag <= 1'b1;
      end else if (rd_data || conv_irq_enable) begin
         conv_complete_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_pend <= 1'b0;
      end else if (trial_done && conv_irq_enable) begin
         irq_pend <= 1'b1;
      end else if (rd_data || wr_csr || !conv_irq_enable) begin
         irq_pend <= 1'b0;
      end
   end

   assign conv_irq = irq_pend;
   assign wake_request = irq_pend;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_ack <= 1'b0;
      end else begin
         rd_ack <= avs_read && !rd_ack;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      if (avs_address == SACC_OFS_CSR) begin
         next_readdata = {24'h00_0000, conv_complete_flag, conv_irq_enable,
                          continuous_conv_bit, channel_select_field};
      end else if (avs_address == SACC_OFS_RHI) begin
         next_readdata = {24'h00_0000, result_high_reg};
      end else if (avs_address == SACC_OFS_RLO) begin
         next_readdata = {24'h00_0000, result_low_reg};
      end else if (avs_address == SACC_OFS_CLK) begin
         next_readdata = {24'h00_0000, conv_clock_prescaler, conv_clock_source_sel,
                          format_sel, 2'b00};
      end
   end

   // Captured in the wait cycle, stands at the taking edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !rd_ack) begin
         avs_readdata <= next_readdata;
      end
   end
endmodule : sacc_ctrl

// [hw/sacc_pkg.sv]
package sacc_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] SACC_OFS_CSR = 4'h0;
   localparam logic [3:0] SACC_OFS_RHI = 4'h4;
   localparam logic [3:0] SACC_OFS_RLO = 4'h8;
   localparam logic [3:0] SACC_OFS_CLK = 4'hC;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SACC_CSR_DONE_POS = 7;
   localparam int SACC_CSR_IEN_POS = 6;
   localparam int SACC_CSR_CONT_POS = 5;
   localparam int SACC_CLK_DIV_POS = 5;
   localparam int SACC_CLK_SRC_POS = 4;
   localparam int SACC_CLK_FMT_POS = 2;
   // ----------------------------------------
   // Reset values and codes
   // ----------------------------------------
   localparam logic [4:0] SACC_CH_RST = 5'h1F;
   localparam logic [4:0] SACC_CH_OFF = 5'h1F;
   localparam logic [4:0] SACC_CH_REFH = 5'h1D;
   localparam logic [4:0] SACC_CH_REFL = 5'h1E;
   localparam logic [4:0] SACC_CH_LAST_PIN = 5'h07;
   localparam logic [1:0] SACC_FMT_TRUNC = 2'h0;
   localparam logic [1:0] SACC_FMT_RIGHT = 2'h1;
   localparam logic [1:0] SACC_FMT_LEFT = 2'h2;
   localparam logic [1:0] SACC_FMT_SIGNED = 2'h3;
   localparam logic [1:0] SACC_FMT_RST = SACC_FMT_RIGHT;
   localparam logic [2:0] SACC_DIV_RST = 3'h0;
   // Trials per conversion plus six sample cycles: 16 converter clocks
   localparam int SACC_CONV_CYCLES = 16;
   localparam int SACC_BITS = 10;

   typedef enum logic [1:0] {SACC_IDLE, SACC_SETTLE, SACC_SAMPLE, SACC_TRIAL} sacc_state_t;
endpackage : sacc_pkg

// [sim/sacc_analog_model.sv]
`timescale 1ns/100ps
module sacc_analog_model (
   input wire logic ref_clk,
   input wire logic [4:0] analog_mux_sel,
   input wire logic analog_power_on,
   input wire logic comparator_sample,
   input wire logic [sacc_pkg::SACC_BITS-1:0] dac_trial_code,
   input wire logic [7:0][9:0] pin_level,
   output logic comparator_above
);
   import sacc_pkg::*;
   logic [9:0] level;
   logic junk = 1'b0;
   // Toggles so an unsampled comparator never looks settled
   always @(posedge ref_clk) junk <= ~junk;
   always_comb begin
      case (analog_mux_sel)
         SACC_CH_REFH: level = 10'h3FF;
         SACC_CH_REFL: level = 10'h000;
         default: level = pin_level[analog_mux_sel[2:0]];
      endcase
      comparator_above = (analog_power_on && comparator_sample) ?
         (level >= dac_trial_code) : junk;
   end
endmodule : sacc_analog_model

// [sim/sacc_ctrl_chk.sv]
`timescale 1ns/100ps
module sacc_ctrl_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic stop_mode,
   input wire logic [4:0] analog_mux_sel,
   input wire logic analog_power_on,
   input wire logic comparator_sample,
   input wire logic [sacc_pkg::SACC_BITS-1:0] dac_trial_code,
   input wire logic [7:0] port_out_req,
   input wire logic [7:0] port_dir_req,
   input wire logic [7:0] shared_analog_port_pins_in,
   input wire logic [7:0] shared_analog_port_pins_out,
   input wire logic [7:0] shared_analog_port_pins_oe,
   input wire logic [7:0] port_read_data,
   input wire logic conv_irq
);
   import sacc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [7:0] claim;
   logic csr_wr;
   assign claim = (analog_mux_sel <= SACC_CH_LAST_PIN) ? (8'h01 << analog_mux_sel[2:0]) : 8'h00;
   assign csr_wr = avs_write && avs_byteenable[0] && (avs_address == SACC_OFS_CSR);
   logic [3:0] trial_cnt;
   // Trials within one conversion; an abort restarts the count
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         trial_cnt <= 4'h0;
      end else if (csr_wr || !analog_power_on) begin
         trial_cnt <= 4'h0;
      end else if (comparator_sample) begin
         trial_cnt <= (trial_cnt == 4'(SACC_BITS - 1)) ? 4'h0 : trial_cnt + 4'h1;
      end
   end
   sequence s_first_trial;
      comparator_sample && trial_cnt == 4'h0 && !stop_mode;
   endsequence
   sequence s_next_trial;
      comparator_sample && trial_cnt == 4'h1 && !stop_mode;
   endsequence
   AST_PIN_OE: assert property (shared_analog_port_pins_oe == (port_dir_req & ~claim))
      else $error("claimed pin enable not masked");
   AST_PIN_OUT: assert property (shared_analog_port_pins_out == (port_out_req & ~claim))
      else $error("claimed pin output not masked");
   AST_PORT_RD: assert property (port_read_data == (shared_analog_port_pins_in & ~claim))
      else $error("port read of claimed pin wrong");
   AST_PWR_OFF: assert property (analog_mux_sel == SACC_CH_OFF |-> !analog_power_on)
      else $error("converter powered with channel off");
   AST_STOP: assert property (stop_mode ##1 stop_mode |-> !comparator_sample && !analog_power_on)
      else $error("converter active in stop");
   AST_IRQ_WR: assert property (csr_wr && !comparator_sample |=> !conv_irq)
      else $error("request kept after control write");
   AST_FIRST_TRIAL: assert property (s_first_trial |-> dac_trial_code == 10'h200)
      else $error("first trial not midscale");
   AST_NEXT_TRIAL: assert property (s_next_trial |-> dac_trial_code[8:0] == 9'h100)
      else $error("second trial code wrong");
endmodule : sacc_ctrl_chk
bind sacc_ctrl sacc_ctrl_chk sacc_ctrl_chk_inst (.ref_clk, .rst, .avs_address, .avs_write,
   .avs_byteenable, .stop_mode, .analog_mux_sel, .analog_power_on, .comparator_sample,
   .dac_trial_code, .port_out_req, .port_dir_req, .shared_analog_port_pins_in,
   .shared_analog_port_pins_out, .shared_analog_port_pins_oe, .port_read_data, .conv_irq);

// [sim/tb_sacc_ctrl.sv]
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; \
   $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb_sacc_ctrl;
   import sacc_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, stop_mode = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
   logic avs_waitrequest, analog_power_on, comparator_sample, comparator_above, conv_irq, wake;
   logic [4:0] analog_mux_sel;
   logic [SACC_BITS-1:0] dac_trial_code;
   logic [7:0] pins_in = 8'hA5, out_req = 8'h5A, dir_req = 8'hF0, pins_out, pins_oe, rd_data;
   logic [7:0][9:0] vin = {10'h3C1, 10'h2AA, 10'h200, 10'h0F0, 10'h1FF, 10'h2D4, 10'h001, 10'h3FE};
   int failures = 0, n_checks = 0;
   sacc_ctrl sacc_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_clk_en(1'b1), .osc_clk_en(1'b1), .stop_mode(stop_mode),
      .analog_mux_sel(analog_mux_sel), .analog_power_on(analog_power_on),
      .comparator_sample(comparator_sample), .dac_trial_code(dac_trial_code),
      .comparator_above(comparator_above), .port_out_req(out_req), .port_dir_req(dir_req),
      .shared_analog_port_pins_in(pins_in), .shared_analog_port_pins_out(pins_out),
      .shared_analog_port_pins_oe(pins_oe), .port_read_data(rd_data), .conv_irq(conv_irq),
      .wake_request(wake));
   sacc_analog_model sacc_analog_model_inst (.ref_clk(ref_clk), .analog_mux_sel(analog_mux_sel),
      .analog_power_on(analog_power_on), .comparator_sample(comparator_sample),
      .dac_trial_code(dac_trial_code), .pin_level(vin), .comparator_above(comparator_above));
   initial forever #50 ref_clk = ~ref_clk;
   task automatic tally_and_finish;
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      logic ws;
      n = 0;
      ws = 1'b1;
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // Waitrequest and read data are settled before the taking edge
      do begin
         @(negedge ref_clk);
         ws = avs_waitrequest;
         q = avs_readdata;
         @(posedge ref_clk);
         n++;
      end while (ws !== 1'b0 && n < 20);
      if (ws !== 1'b0) begin
         failures++;
         tally_and_finish();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(negedge ref_clk);
   endtask : bus
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         bus(1'b0, SACC_OFS_CSR, 32'h0);
         n++;
      end while (q[SACC_CSR_DONE_POS] !== 1'b1 && n < 100);
      if (n >= 100) begin failures++; tally_and_finish(); end
   endtask : wait_done
   task automatic wait_irq;
      int n;
      n = 0;
      while (conv_irq !== 1'b1 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 200) begin failures++; tally_and_finish(); end
   endtask : wait_irq
   function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] r);
      case (f)
         SACC_FMT_TRUNC: return {8'h00, r[9:2]};
         SACC_FMT_RIGHT: return {6'h00, r};
         SACC_FMT_LEFT: return {r, 6'h00};
         default: return {~r[9], r[8:0], 6'h00};
      endcase
   endfunction : fmt_exp
   task automatic conv(input logic [4:0] ch, input logic [1:0] f, input logic [9:0] r);
      logic [15:0] e;
      logic [7:0] m;
      e = fmt_exp(f, r);
      m = (ch < 5'h08) ? ~(8'h01 << ch[2:0]) : 8'hFF;
      bus(1'b1, SACC_OFS_CLK, {28'h0, f, 2'h0});
      bus(1'b1, SACC_OFS_CSR, {27'h0, ch});
      `CHK("pin oe", dir_req & m, pins_oe)
      `CHK("pin out", out_req & m, pins_out)
      `CHK("port read", pins_in & m, rd_data)
      wait_done();
      bus(1'b0, SACC_OFS_RHI, 32'h0);
      `CHK("result high", {24'h0, e[15:8]}, q)
      bus(1'b0, SACC_OFS_RLO, 32'h0);
      `CHK("result low", {24'h0, e[7:0]}, q)
      bus(1'b0, SACC_OFS_CSR, 32'h0);
      `CHK("flag clear", {27'h0, ch}, q)
   endtask : conv
   task automatic s_reset;
      `CHK("power", 1'b0, analog_power_on)
      bus(1'b0, SACC_OFS_CSR, 32'h0);
      `CHK("csr reset", {27'h0, SACC_CH_RST}, q)
      bus(1'b0, SACC_OFS_CLK, 32'h0);
      `CHK("clk reset", 32'h0000_0004, q)
      bus(1'b0, 4'h2, 32'h0);
      `CHK("unmapped", 32'h0000_0000, q)
   endtask : s_reset
   task automatic s_convs;
      for (int i = 0; i < 8; i++) conv(5'(i), 2'(i), vin[i]);
      conv(SACC_CH_REFH, SACC_FMT_RIGHT, 10'h3FF);
      conv(SACC_CH_REFL, SACC_FMT_LEFT, 10'h000);
   endtask : s_convs
   task automatic s_cont;
      bus(1'b1, SACC_OFS_CLK, 32'h0000_0004);
      bus(1'b1, SACC_OFS_CSR, 32'h0000_0022);
      wait_done();
      bus(1'b0, SACC_OFS_RHI, 32'h0);
      vin[2] <= 10'h1C3;
      repeat (80) @(posedge ref_clk);
      bus(1'b0, SACC_OFS_RLO, 32'h0);
      `CHK("locked low", 32'h0000_00D4, q)
      repeat (80) @(posedge ref_clk);
      bus(1'b0, SACC_OFS_RHI, 32'h0);
      `CHK("fresh high", 32'h0000_0001, q)
      bus(1'b0, SACC_OFS_RLO, 32'h0);
      `CHK("fresh low", 32'h0000_00C3, q)
      bus(1'b1, SACC_OFS_CSR, {27'h0, SACC_CH_OFF});
   endtask : s_cont
   task automatic s_irq;
      bus(1'b1, SACC_OFS_CSR, 32'h0000_0041);
      wait_irq();
      bus(1'b0, SACC_OFS_CSR, 32'h0);
      `CHK("flag in irq mode", 32'h0000_0041, q)
      bus(1'b1, SACC_OFS_CSR, 32'h0000_0041);
      `CHK("irq after write", 1'b0, conv_irq)
      wait_irq();
      `CHK("wake", 1'b1, wake)
      bus(1'b0, SACC_OFS_RHI, 32'h0);
      `CHK("irq after read", 1'b0, conv_irq)
      bus(1'b0, SACC_OFS_RLO, 32'h0);
   endtask : s_irq
   task automatic s_stop;
      bus(1'b1, SACC_OFS_CSR, 32'h0000_0003);
      repeat (6) @(posedge ref_clk);
      bus(1'b1, SACC_OFS_CSR, 32'h0000_0003);
      wait_done();
      bus(1'b0, SACC_OFS_RHI, 32'h0);
      `CHK("restart high", {30'h0, vin[3][9:8]}, q)
      bus(1'b0, SACC_OFS_RLO, 32'h0);
      `CHK("restart low", {24'h0, vin[3][7:0]}, q)
      bus(1'b1, SACC_OFS_CSR, 32'h0000_0004);
      repeat (8) @(posedge ref_clk);
      stop_mode <= 1'b1;
      repeat (40) @(posedge ref_clk);
      stop_mode <= 1'b0;
      bus(1'b0, SACC_OFS_CSR, 32'h0);
      `CHK("flag after stop", 32'h0000_0004, q)
      wait_done();
      bus(1'b0, SACC_OFS_RHI, 32'h0);
      `CHK("resumed high", {30'h0, vin[4][9:8]}, q)
   endtask : s_stop
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      @(negedge ref_clk);
      s_reset();
      s_convs();
      s_cont();
      s_irq();
      s_stop();
      tally_and_finish();
   end
endmodule : tb_sacc_ctrl
